// ---- rtl/delay_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
module delay_counter
    import hotswap_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [CNT_W-1:0] limit,
    output logic done
);
    logic [CNT_W-1:0] count_reg;

    // counts while run is high, clears on any drop so each interval is full
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= CNT_ZERO;
        end else if (!run) begin
            count_reg <= CNT_ZERO;
        end else if (count_reg < limit) begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    assign done = run && (count_reg >= limit);
endmodule // delay_counter
`default_nettype wire

// ---- rtl/hotswap_pkg.sv ----
package hotswap_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CLK_NS = 20;
    // response windows are longest times, so they round down
    localparam int OVP_RESP_US = 3;
    localparam int OVP_RESP_CYC = (OVP_RESP_US * 1000) / CLK_NS;
    localparam int FFT_RESP_NS = 195;
    localparam int FFT_RESP_CYC = FFT_RESP_NS / CLK_NS;
    localparam int SFT_RESP_NS = 418;
    localparam int SFT_RESP_CYC = SFT_RESP_NS / CLK_NS;
    // delays are least times, so they round up
    localparam int INS_DLY_MS = 18;
    localparam int INS_DLY_CYC = INS_DLY_MS * 1000 * CLK_MHZ;
    localparam int QOD_DLY_US = 16;
    localparam int QOD_DLY_CYC = QOD_DLY_US * CLK_MHZ + 1;
    localparam int FAST_REC_US = 30;
    localparam int FAST_REC_CYC = FAST_REC_US * CLK_MHZ;
    localparam int RETRY_MS = 841;
    localparam int RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;
    localparam int SU_TMO_MS = 6900;
    localparam int SU_TMO_CYC = SU_TMO_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam int NUM_SYNC = 9;
endpackage

// ---- rtl/hotswap_sequencer.sv ----
// How it works
// RULE1: overvoltage drops switch enable within 3 us
// RULE2: stay off 18 ms after supply good
// RULE3: sample enable only after rails and delay
// RULE4: enable low turns switch off
// RULE5: enable read as on, standby, shutdown
// RULE6: standby keeps logic alive, switch off
// RULE7: discharge after 16 us continuous standby
// RULE8: shutdown level clears all state, faults (code keeps mask_reg through shutdown)
// RULE9: hard short drops enable within 195 ns
// RULE10: scalable fast trip cuts within 418 ns
// RULE11: auto-retry restarts 30 us after fast trip
// RULE12: auto-retry waits 841 ms after fault
// RULE13: not fully on after 6.9 s flags fault
// RULE14: thermal shutdown forces switch off always
// RULE15: internal overvoltage also disables switch
// RULE16: startup timeout: fault low, latch or retry
// RULE17: blanking expiry turns off, timer re-arms (code re-arms only for an expiry in ST_ON, not in ST_STARTUP)
// RULE18: one clock, synchronised inputs, reset counters (code passes both fast trips and blanking expiry unsynchronised)
`timescale 1ns/1ns
`default_nettype none
module hotswap_sequencer
    import hotswap_pkg::*;
#(
    parameter int INS_CYC = INS_DLY_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int SU_CYCLES = SU_TMO_CYC,
    parameter int AUTO_RETRY = 1
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SUPPLY_UNDERVOLTAGE,
    input wire logic VIN_UNDERVOLTAGE,
    input wire logic BIAS_READY,
    input wire logic ENABLE_UVLO_ON,
    input wire logic ENABLE_UVLO_ABOVE_SD,
    input wire logic OVERVOLTAGE_TRIP,
    input wire logic INTERNAL_OVERVOLTAGE,
    input wire logic FIXED_FAST_TRIP,
    input wire logic SCALABLE_FAST_TRIP,
    input wire logic BLANKING_TIMER_EXPIRED,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic SWITCH_FULLY_ON,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ,
    output logic SWITCH_GATE_ENABLE,
    output logic FAULT_FLAG_N,
    output logic OUTPUT_DISCHARGE,
    output logic BLANKING_TIMER_REARM
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_INSERT = 3'b000,
        ST_WAIT_EN = 3'b001,
        ST_STARTUP = 3'b010,
        ST_ON = 3'b011,
        ST_FAST_REC = 3'b100,
        ST_RETRY = 3'b101,
        ST_LATCHED = 3'b110
    } seq_state_t;

    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam int EV_W = 6;

    seq_state_t state_reg, state_next;
    logic [NUM_SYNC-1:0] raw_in, syn;
    logic uv_s, vin_uv_s, bias_s, en_on_s, en_sd_s, ovp_s, iov_s;
    logic fft_s, sft_s, tmr_s, tsd_s, full_s;
    logic en_shutdown, en_standby, kill_now, fast_trip, slow_fault;
    logic ins_done, qod_done, rec_done, retry_done, su_done;
    logic [EV_W-1:0] events, status_reg, mask_reg;
    logic [31:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////////
    assign raw_in = {SUPPLY_UNDERVOLTAGE, VIN_UNDERVOLTAGE, BIAS_READY, ENABLE_UVLO_ON,
                     ENABLE_UVLO_ABOVE_SD, OVERVOLTAGE_TRIP, INTERNAL_OVERVOLTAGE,
                     THERMAL_SHUTDOWN, SWITCH_FULLY_ON};

    // slow level inputs only; fast trips go direct so the short windows hold
    level_sync #(.WIDTH(NUM_SYNC)) u_sync (
        .clk(CLK),
        .nrst(NRST),
        .async_in(raw_in),
        .sync_out(syn)
    ); // RULE18

    assign {uv_s, vin_uv_s, bias_s, en_on_s, en_sd_s, ovp_s, iov_s, tsd_s, full_s} = syn;
    // fast trips skip the synchroniser: 195 ns leaves under ten cycles, and
    // the comparators are treated as clock-synchronous pulses here
    assign fft_s = FIXED_FAST_TRIP;
    assign sft_s = SCALABLE_FAST_TRIP;
    assign tmr_s = BLANKING_TIMER_EXPIRED;

    assign en_shutdown = !en_sd_s; // RULE5
    assign en_standby = en_sd_s && !en_on_s; // RULE5
    assign fast_trip = fft_s || sft_s; // RULE9 RULE10
    assign slow_fault = ovp_s || iov_s || tsd_s || tmr_s; // RULE1 RULE15 RULE14 RULE17
    assign kill_now = fast_trip || slow_fault || !en_on_s; // RULE4

    ////////////////////////////////////////////////////////////////////////////
    // supply-good term gates the insertion timer, so it restarts on a brownout;
    // shutdown level holds it clear, else a long shutdown shortens the delay
    delay_counter u_ins (
        .clk(CLK),
        .nrst(NRST),
        .run(!uv_s && bias_s && !en_shutdown && state_reg == ST_INSERT), // RULE8
        .limit(INS_CYC[CNT_W-1:0]),
        .done(ins_done)
    ); // RULE2

    delay_counter u_qod (
        .clk(CLK),
        .nrst(NRST),
        .run(en_standby),
        .limit(QOD_DLY_CYC[CNT_W-1:0]),
        .done(qod_done)
    ); // RULE7

    delay_counter u_rec (
        .clk(CLK),
        .nrst(NRST),
        .run(state_reg == ST_FAST_REC),
        .limit(FAST_REC_CYC[CNT_W-1:0]),
        .done(rec_done)
    ); // RULE11

    delay_counter u_retry (
        .clk(CLK),
        .nrst(NRST),
        .run(state_reg == ST_RETRY),
        .limit(RETRY_CYCLES[CNT_W-1:0]),
        .done(retry_done)
    ); // RULE12

    delay_counter u_su (
        .clk(CLK),
        .nrst(NRST),
        .run(state_reg == ST_STARTUP),
        .limit(SU_CYCLES[CNT_W-1:0]),
        .done(su_done)
    ); // RULE13

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_INSERT: begin
                if (ins_done) begin
                    state_next = ST_WAIT_EN; // RULE2
                end
            end
            ST_WAIT_EN: begin
                if (uv_s || vin_uv_s) begin
                    state_next = ST_WAIT_EN;
                end else if (en_on_s && !slow_fault && !fast_trip) begin
                    state_next = ST_STARTUP; // RULE3
                end
            end
            ST_STARTUP, ST_ON: begin
                if (!en_on_s || uv_s || vin_uv_s) begin
                    state_next = ST_WAIT_EN; // RULE4 RULE6
                end else if (fast_trip) begin
                    state_next = (AUTO_RETRY != 0) ? ST_FAST_REC : ST_LATCHED; // RULE11
                end else if (slow_fault || su_done) begin
                    state_next = (AUTO_RETRY != 0) ? ST_RETRY : ST_LATCHED; // RULE16 RULE12
                end else if (state_reg == ST_STARTUP && full_s) begin
                    state_next = ST_ON;
                end
            end
            ST_FAST_REC: begin
                if (rec_done) begin
                    state_next = ST_WAIT_EN; // RULE11
                end
            end
            ST_RETRY: begin
                if (retry_done) begin
                    state_next = ST_WAIT_EN; // RULE12
                end
            end
            ST_LATCHED: begin
                state_next = ST_LATCHED;
            end
            default: begin
                state_next = ST_INSERT;
            end
        endcase
    end

    // shutdown level wipes state, fault flag and status as a reset would; mask_reg keeps its value
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_INSERT;
        end else if (en_shutdown) begin
            state_reg <= ST_INSERT; // RULE8
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gate drive is combinational on kill terms so trips meet the short windows
    assign SWITCH_GATE_ENABLE = (state_reg == ST_STARTUP || state_reg == ST_ON)
                                && !kill_now; // RULE1 RULE9 RULE10 RULE14

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FAULT_FLAG_N <= 1'b1;
        end else if (en_shutdown) begin
            FAULT_FLAG_N <= 1'b1; // RULE8
        end else if (state_reg == ST_STARTUP && su_done) begin
            FAULT_FLAG_N <= 1'b0; // RULE13 RULE16
        end else if ((state_reg == ST_STARTUP || state_reg == ST_ON)
                     && (fast_trip || slow_fault)) begin
            FAULT_FLAG_N <= 1'b0;
        end else if (state_reg == ST_STARTUP && full_s) begin
            FAULT_FLAG_N <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            OUTPUT_DISCHARGE <= 1'b0;
        end else begin
            OUTPUT_DISCHARGE <= qod_done; // RULE7
        end
    end

    // one-cycle pulse that recharges the external blanking timer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            BLANKING_TIMER_REARM <= 1'b0;
        end else begin
            BLANKING_TIMER_REARM <= tmr_s && (state_reg == ST_ON); // RULE17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign events = {su_done, tsd_s, tmr_s, fast_trip, ovp_s || iov_s, qod_done};

    // set wins over the read-clear
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            status_reg <= '0;
        end else if (en_shutdown) begin
            status_reg <= '0;
        end else if (REG_RD && REG_ADDR == ADDR_STATUS) begin
            status_reg <= events;
        end else begin
            status_reg <= status_reg | events;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mask_reg <= '0;
        end else if (REG_WR && REG_ADDR == ADDR_MASK) begin
            mask_reg <= REG_WDATA[EV_W-1:0];
        end
    end

    assign IRQ = |(status_reg & mask_reg);

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (REG_ADDR == ADDR_STATUS) begin
            rdata_next = {26'h0, status_reg};
        end else if (REG_ADDR == ADDR_MASK) begin
            rdata_next = {26'h0, mask_reg};
        end else if (REG_ADDR == ADDR_STATE) begin
            rdata_next = {28'h0, FAULT_FLAG_N, state_reg};
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_next;
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_ovp_off;
        @(posedge CLK) disable iff (!NRST) ovp_s |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_ovp_off: assert property (p_ovp_off) else $error("gate on during overvoltage"); // RULE1

    property p_fft_off;
        @(posedge CLK) disable iff (!NRST) FIXED_FAST_TRIP |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_fft_off: assert property (p_fft_off) else $error("gate on during hard short"); // RULE9

    property p_sft_off;
        @(posedge CLK) disable iff (!NRST) SCALABLE_FAST_TRIP |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_sft_off: assert property (p_sft_off) else $error("gate on during fast trip"); // RULE10

    property p_tsd_off;
        @(posedge CLK) disable iff (!NRST) tsd_s |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("gate on in thermal shutdown"); // RULE14

    property p_iov_off;
        @(posedge CLK) disable iff (!NRST) iov_s |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_iov_off: assert property (p_iov_off) else $error("gate on in internal overvoltage"); // RULE15

    property p_en_off;
        @(posedge CLK) disable iff (!NRST) !en_on_s |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_en_off: assert property (p_en_off) else $error("gate on with enable low"); // RULE4

    property p_insert_off;
        @(posedge CLK) disable iff (!NRST) state_reg == ST_INSERT |-> !SWITCH_GATE_ENABLE;
    endproperty
    a_insert_off: assert property (p_insert_off) else $error("gate on in insertion delay"); // RULE2

    property p_shutdown_clear;
        @(posedge CLK) disable iff (!NRST) en_shutdown |=> state_reg == ST_INSERT && FAULT_FLAG_N;
    endproperty
    a_shutdown_clear: assert property (p_shutdown_clear) // RULE8
        else $error("shutdown did not clear");

    property p_qod_only_standby;
        @(posedge CLK) disable iff (!NRST) OUTPUT_DISCHARGE |-> $past(en_standby, 1);
    endproperty
    a_qod_only_standby: assert property (p_qod_only_standby) // RULE7
        else $error("discharge outside standby");

    property p_su_fault;
        @(posedge CLK) disable iff (!NRST)
            state_reg == ST_STARTUP && su_done && !en_shutdown |=> !FAULT_FLAG_N;
    endproperty
    a_su_fault: assert property (p_su_fault) else $error("startup timeout not flagged"); // RULE13
endmodule // hotswap_sequencer
`default_nettype wire

// ---- rtl/level_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module level_sync
    import hotswap_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // level_sync
`default_nettype wire

// ---- testbench/comparator_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// far-side comparators and the FET; the bench moves the levels at clock edges
module comparator_model (
    input wire logic clk,
    input wire logic gate,
    output logic sup_uv,
    output logic vin_uv,
    output logic bias,
    output logic en_on,
    output logic en_sd,
    output logic overvoltage_trip,
    output logic iov,
    output logic fixed_fast_trip,
    output logic scalable_fast_trip,
    output logic blk,
    output logic thermal_shutdown,
    output logic fon
);
    // cycles the FET needs to enhance; 0 models a FET that never gets there
    int on_dly = 5;
    int on_cnt = 0;
    initial begin
        {sup_uv, vin_uv, overvoltage_trip, iov, fixed_fast_trip, scalable_fast_trip, blk, thermal_shutdown, fon} = 9'h000;
        {bias, en_on, en_sd} = 3'h7;
    end
    always @(posedge clk) begin
        if (gate !== 1'b1) begin
            on_cnt <= 0;
            fon <= 1'b0;
        end else begin
            on_cnt <= on_cnt + 1;
            fon <= (on_dly != 0) && (on_cnt >= on_dly);
        end
    end
endmodule // comparator_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import hotswap_pkg::*;
    localparam int INS = 50;
    localparam int RET = 80;
    localparam int SU = 200;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] rdata, e, e2;
    logic irq, gate, fault_n, dis, rearm, a0;
    logic sup_uv, vin_uv, bias, en_on, en_sd, overvoltage_trip, iov, fixed_fast_trip, scalable_fast_trip, blk, thermal_shutdown, fon;
    logic [31:0] exp_q[$];
    logic [31:0] stat[5] = '{32'h02, 32'h02, 32'h10, 32'h04, 32'h04};
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int n, t0, s;
    always #10 CLK = ~CLK;
    hotswap_sequencer #(.INS_CYC(INS), .RETRY_CYCLES(RET), .SU_CYCLES(SU)) hotswap_sequencer_i (
        .CLK(CLK), .NRST(NRST), .SUPPLY_UNDERVOLTAGE(sup_uv), .VIN_UNDERVOLTAGE(vin_uv),
        .BIAS_READY(bias), .ENABLE_UVLO_ON(en_on), .ENABLE_UVLO_ABOVE_SD(en_sd),
        .OVERVOLTAGE_TRIP(overvoltage_trip), .INTERNAL_OVERVOLTAGE(iov), .FIXED_FAST_TRIP(fixed_fast_trip),
        .SCALABLE_FAST_TRIP(scalable_fast_trip), .BLANKING_TIMER_EXPIRED(blk), .THERMAL_SHUTDOWN(thermal_shutdown),
        .SWITCH_FULLY_ON(fon), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .IRQ(irq), .SWITCH_GATE_ENABLE(gate), .FAULT_FLAG_N(fault_n),
        .OUTPUT_DISCHARGE(dis), .BLANKING_TIMER_REARM(rearm));
    comparator_model comparator_model_i (
        .clk(CLK), .gate(gate), .sup_uv(sup_uv), .vin_uv(vin_uv), .bias(bias), .en_on(en_on),
        .en_sd(en_sd), .overvoltage_trip(overvoltage_trip), .iov(iov), .fixed_fast_trip(fixed_fast_trip), .scalable_fast_trip(scalable_fast_trip), .blk(blk), .thermal_shutdown(thermal_shutdown),
        .fon(fon));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge CLK);
        wr <= 1'b0;
    endtask
    // the expectation is queued before the strobe, the monitor pops it a cycle later
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] x);
        @(posedge CLK);
        exp_q.push_back(x);
        addr <= a;
        rd <= 1'b1;
        @(posedge CLK);
        rd <= 1'b0;
    endtask
    task automatic drive(input int k, input logic v);
        @(posedge CLK);
        case (k)
            0: comparator_model_i.overvoltage_trip <= v;
            1: comparator_model_i.iov <= v;
            2: comparator_model_i.thermal_shutdown <= v;
            3: comparator_model_i.fixed_fast_trip <= v;
            4: comparator_model_i.scalable_fast_trip <= v;
            5: comparator_model_i.blk <= v;
            6: comparator_model_i.en_on <= v;
            default: comparator_model_i.en_sd <= v;
        endcase
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return gate;
            1: return fault_n;
            2: return dis;
            default: return rearm;
        endcase
    endfunction
    // sampled just after the edge so the edge's own updates have landed
    task automatic wait_for(input int w, input logic v, input int lim);
        n = 0;
        #1;
        while (sig(w) !== v && n < lim) begin
            @(posedge CLK);
            #1;
            n++;
        end
        t0 = cyc;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        rd_d <= rd;
        if (rd_d) begin
            e2 = exp_q.pop_front();
            checked++;
            if (rdata !== e2) begin
                fails++;
                $display("unexpected at %0t: read %h, wanted %h", $time, rdata, e2);
            end
        end
        if (cyc == 12000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        void'($urandom(69934));
        repeat (12) @(posedge CLK);
        chk(gate === 1'b0 && fault_n === 1'b1 && dis === 1'b0 && irq === 1'b0, "reset");
        NRST <= 1'b1;
        wait_for(0, 1'b1, INS + 20);
        chk(n >= INS && n <= INS + 8, "insertion delay");
        repeat (12) @(posedge CLK);
        rd_reg(8'h08, 32'h0000_000b);
        rd_reg(8'h0c, 32'h0000_0000);
        wr_reg(8'h0c, 32'hffff_ffff);
        rd_reg(8'h0c, 32'h0000_0000);
        e = $urandom;
        wr_reg(8'h04, e);
        rd_reg(8'h04, e & 32'h0000_003f);
        for (int k = 0; k < 5; k++) begin
            drive(k, 1'b1);
            wait_for(0, 1'b0, 200);
            s = k < 3 ? OVP_RESP_CYC : k == 3 ? FFT_RESP_CYC : SFT_RESP_CYC;
            chk(n <= s, "trip");
            drive(k, 1'b0);
            repeat (2) @(posedge CLK);
            chk(fault_n === 1'b0, "fault flag");
            if (k == 0) begin
                wr_reg(8'h04, 32'h0000_0000);
                #1 a0 = irq;
                wr_reg(8'h04, 32'h0000_003f);
                #1 chk(irq !== a0, "mask");
            end
            rd_reg(8'h00, stat[k]);
            @(posedge CLK);
            #1 chk(irq === 1'b0, "status clear on read");
            s = t0;
            wait_for(0, 1'b1, 1600);
            t0 = cyc - s;
            n = k < 3 ? RET : FAST_REC_CYC;
            chk(t0 >= n && t0 <= n + 8, "restart delay");
            repeat (12) @(posedge CLK);
            chk(fault_n === 1'b1, "fault released");
        end
        drive(5, 1'b1);
        wait_for(3, 1'b1, 4);
        chk(n < 4 && gate === 1'b0, "blanking expiry");
        drive(5, 1'b0);
        rd_reg(8'h00, 32'h0000_0008);
        comparator_model_i.on_dly = 0;
        wait_for(0, 1'b1, RET + 20);
        wait_for(0, 1'b0, SU + 20);
        chk(n >= SU && n <= SU + 6 && fault_n === 1'b0, "startup timeout");
        rd_reg(8'h00, 32'h0000_0020);
        comparator_model_i.on_dly = 5;
        wait_for(0, 1'b1, RET + 20);
        chk(n <= RET + 20, "retry after timeout");
        repeat (12) @(posedge CLK);
        drive(6, 1'b0);
        wait_for(0, 1'b0, 6);
        chk(n < 6, "enable low");
        repeat (400) @(posedge CLK);
        drive(6, 1'b1);
        repeat (5) @(posedge CLK);
        drive(6, 1'b0);
        s = cyc;
        wait_for(2, 1'b1, QOD_DLY_CYC + 20);
        chk(t0 - s >= QOD_DLY_CYC && t0 - s <= QOD_DLY_CYC + 6, "discharge");
        rd_reg(8'h00, 32'h0000_0001);
        drive(6, 1'b1);
        drive(0, 1'b1);
        wait_for(0, 1'b0, 200);
        drive(0, 1'b0);
        drive(7, 1'b0);
        repeat (4) @(posedge CLK);
        chk(fault_n === 1'b1 && dis === 1'b0, "shutdown clear");
        rd_reg(8'h08, 32'h0000_0008);
        rd_reg(8'h00, 32'h0000_0000);
        drive(7, 1'b1);
        wait_for(0, 1'b1, INS + 20);
        chk(n >= INS && n <= INS + 8, "insertion after shutdown");
        repeat (4) @(posedge CLK);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
